// ==== common/pfvr_consts.vh ====
`ifndef PFVR_CONSTS_VH
`define PFVR_CONSTS_VH

// Register byte offsets
`define PFVR_OFF_STATUS 8'h00
`define PFVR_OFF_INDEX 8'h04
`define PFVR_OFF_PARAM 8'h08
`define PFVR_OFF_MODE 8'h0C
`define PFVR_OFF_PROT 8'h10

// Status register bit positions
`define PFVR_BIT_CCF 7
`define PFVR_BIT_ACC 5
`define PFVR_BIT_PROT 4
`define PFVR_BIT_ANY 1
`define PFVR_BIT_UNC 0

// Reset values
`define PFVR_RST_MODE 3'h7
`define PFVR_RST_PROT 16'hFFFF

// Command codes
`define PFVR_CMD_EV_SECT 8'h03
`define PFVR_CMD_RD_ONCE 8'h04
`define PFVR_CMD_PROG 8'h06

// Parameter index required at launch, first stored one-time-read word, last fetched entry
`define PFVR_IX_EV_SECT 3'h2
`define PFVR_IX_RD_ONCE 3'h1
`define PFVR_IX_PROG 3'h5
`define PFVR_IX_WORD0 3'h2
`define PFVR_IX_LAST 3'h5

// Address map, erased value and phrase size of the program flash
`define PFVR_BLK_LO 7'h40
`define PFVR_BLK_HI 7'h7F
`define PFVR_ONCE_MAX 16'h0007
`define PFVR_ERASED 64'hFFFFFFFFFFFFFFFF
`define PFVR_PHRASE_BYTES 24'h000008

// Bus responses
`define PFVR_RESP_OKAY 2'h0
`define PFVR_RESP_SLVERR 2'h2

`endif

// ==== logic/pfvr_launch_chk.v ====
`timescale 1ns/10ps
`default_nettype none
`include "pfvr_consts.vh"

module pfvr_launch_chk (
    // Captured launch parameters
    input wire [7:0] cmd,
    input wire [2:0] idx,
    input wire [6:0] blk,
    input wire [15:0] addr_lo,
    input wire [15:0] count,
    // Mode and protection settings
    input wire [2:0] cmd_allowed,
    input wire [15:0] prot_base,
    // Results
    output reg acc_err,
    output reg prot_err
);
    wire [23:0] start = {1'b0, blk, addr_lo};
    wire [23:0] last = start + {5'h00, count, 3'h0} - `PFVR_PHRASE_BYTES;
    wire blk_ok = (blk >= `PFVR_BLK_LO) && (blk <= `PFVR_BLK_HI);
    wire aligned = (addr_lo[2:0] == 3'h0);

    always @* begin
        acc_err = 1'b0;
        prot_err = 1'b0;
        case (cmd)
            `PFVR_CMD_EV_SECT: begin
                if (idx != `PFVR_IX_EV_SECT) acc_err = 1'b1;
                if (!cmd_allowed[0]) acc_err = 1'b1;
                if (!aligned) acc_err = 1'b1;
                if (!blk_ok) acc_err = 1'b1;
                if (count == 16'h0000) acc_err = 1'b1;
                if (last[23:17] != start[23:17]) acc_err = 1'b1;
            end
            `PFVR_CMD_RD_ONCE: begin
                if (idx != `PFVR_IX_RD_ONCE) acc_err = 1'b1;
                if (!cmd_allowed[1]) acc_err = 1'b1;
                if (addr_lo > `PFVR_ONCE_MAX) acc_err = 1'b1;
            end
            `PFVR_CMD_PROG: begin
                if (idx != `PFVR_IX_PROG) acc_err = 1'b1;
                if (!cmd_allowed[2]) acc_err = 1'b1;
                if (!aligned) acc_err = 1'b1;
                if (!blk_ok) acc_err = 1'b1;
                prot_err = (addr_lo >= prot_base);
            end
            default: acc_err = 1'b1;
        endcase
    end
endmodule // pfvr_launch_chk
`default_nettype wire

// ==== logic/pfvr_param_mem.v ====
`timescale 1ns/10ps
`default_nettype none
`include "pfvr_consts.vh"

module pfvr_param_mem (
    // Clock
    input wire aclk,
    // Write port
    input wire we,
    input wire [2:0] waddr,
    input wire [15:0] wdata,
    // Registered read ports
    input wire [2:0] raddr_a,
    output reg [15:0] rdata_a,
    input wire [2:0] raddr_b,
    output reg [15:0] rdata_b
);
    reg [15:0] mem [0:7];

    always @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_a <= mem[raddr_a];
        rdata_b <= mem[raddr_b];
    end
endmodule // pfvr_param_mem
`default_nettype wire

// ==== logic/pfvr_seq.v ====
// Summary of operation
// - Section erase-verify: code 0x03 plus block at 000, address 001, phrase count 010.
// - Access error, no run, when the verified section crosses a 128 Kbyte boundary.
// - Erase-verify launch with parameter index other than 010 raises access error.
// - Erase-verify and program need phrase-aligned address, low three bits 000.
// - Erase-verify and program flag access error on an unmapped 23-bit address.
// - Any of the three commands disabled in current mode raises access error.
// - Clearing command-complete launches; it stays clear until the operation ends.
// - Erase-verify and one-time read flag any read error and uncorrectable errors.
// - Program read-back verify flags any error and uncorrectable errors.
// - Program to protected area sets protection violation; other commands never do.
// - One-time read: code 0x04, phrase index 0 to 7 at index 001.
// - One-time read places the four fetched words at parameter entries 010 to 101.
// - One-time read launch with parameter index other than 001 raises access error.
// - One-time read phrase index beyond seven raises access error.
// - Ordinary reads of program flash return invalid data during one-time read.
// - Program: code 0x06, block at 000, phrase address 001, data 010 to 101.
// - Program launch with parameter index other than 101 raises access error.
// - Program writes four words, reads them back and compares before completing.
// - A failed parameter check sets access error, a failed protection check sets protection violation; either way the command is not run.
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "pfvr_consts.vh"

module pfvr_seq (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address and data
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Flash array port
    output reg fl_req,
    output reg fl_we,
    output reg fl_once,
    output reg [22:0] fl_addr,
    output reg [63:0] fl_wdata,
    input wire fl_ack,
    input wire [63:0] fl_rdata,
    input wire fl_rerr,
    input wire fl_runc,
    // Status toward the flash read path
    output reg pflash_read_invalid
);
    localparam [7:0] S_IDLE = 8'h01;
    localparam [7:0] S_FETCH = 8'h02;
    localparam [7:0] S_CAPT = 8'h04;
    localparam [7:0] S_CHECK = 8'h08;
    localparam [7:0] S_RD = 8'h10;
    localparam [7:0] S_WR = 8'h20;
    localparam [7:0] S_STORE = 8'h40;
    localparam [7:0] S_DONE = 8'h80;

    reg [7:0] state;
    reg command_complete_flag;
    reg access_error_flag;
    reg protection_violation_flag;
    reg any_read_error_flag;
    reg uncorrectable_error_flag;
    reg [2:0] param_array_index;
    reg [2:0] cmd_allowed;
    reg [15:0] prot_base;
    reg [2:0] launch_idx;
    reg [15:0] prm [0:5];
    reg [2:0] fetch_idx;
    reg [22:0] cur_addr;
    reg [15:0] remaining;
    reg [63:0] phrase;
    reg [1:0] store_cnt;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;

    wire wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire wr_status = wr_fire && (aw_addr == `PFVR_OFF_STATUS) && w_strb[0];
    wire wr_index = wr_fire && (aw_addr == `PFVR_OFF_INDEX) && w_strb[0];
    wire wr_param = wr_fire && (aw_addr == `PFVR_OFF_PARAM) && (w_strb[1:0] == 2'h3);
    wire wr_mode = wr_fire && (aw_addr == `PFVR_OFF_MODE) && w_strb[0];
    wire wr_prot = wr_fire && (aw_addr == `PFVR_OFF_PROT) && (w_strb[1:0] == 2'h3);
    wire wr_known = (aw_addr == `PFVR_OFF_STATUS) || (aw_addr == `PFVR_OFF_INDEX) ||
        (aw_addr == `PFVR_OFF_PARAM) || (aw_addr == `PFVR_OFF_MODE) || (aw_addr == `PFVR_OFF_PROT);
    wire launch = wr_status && w_data[`PFVR_BIT_CCF] && command_complete_flag &&
        !access_error_flag && !protection_violation_flag;
    wire clr_acc = wr_status && w_data[`PFVR_BIT_ACC];
    wire clr_prot = wr_status && w_data[`PFVR_BIT_PROT];

    wire [15:0] bus_rdata;
    wire [15:0] seq_rdata;
    wire acc_err;
    wire prot_err;
    wire seq_we = (state == S_STORE);
    wire mem_we = seq_we || (wr_param && command_complete_flag);
    wire [2:0] mem_waddr = seq_we ? (`PFVR_IX_WORD0 + {1'b0, store_cnt}) : param_array_index;
    reg [15:0] store_word;

    always @* begin
        case (store_cnt)
            2'h0: store_word = phrase[15:0];
            2'h1: store_word = phrase[31:16];
            2'h2: store_word = phrase[47:32];
            default: store_word = phrase[63:48];
        endcase
    end

    wire [15:0] mem_wdata = seq_we ? store_word : w_data[15:0];

    pfvr_param_mem u_mem (
        .aclk(aclk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr_a(param_array_index),
        .rdata_a(bus_rdata),
        .raddr_b(fetch_idx),
        .rdata_b(seq_rdata)
    );

    pfvr_launch_chk u_chk (
        .cmd(prm[0][15:8]),
        .idx(launch_idx),
        .blk(prm[0][6:0]),
        .addr_lo(prm[1]),
        .count(prm[2]),
        .cmd_allowed(cmd_allowed),
        .prot_base(prot_base),
        .acc_err(acc_err),
        .prot_err(prot_err)
    );

    wire [63:0] prog_data = {prm[5], prm[4], prm[3], prm[2]};
    wire rd_bad = fl_rerr || fl_runc;
    wire cmd_ev = (prm[0][15:8] == `PFVR_CMD_EV_SECT);
    wire cmd_once = (prm[0][15:8] == `PFVR_CMD_RD_ONCE);

    // Bus write channels and write response
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PFVR_RESP_OKAY;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awready && s_axi_awvalid) begin
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wready && s_axi_wvalid) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? `PFVR_RESP_OKAY : `PFVR_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Bus read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PFVR_RESP_OKAY;
        end else begin
            if (s_axi_arready && s_axi_arvalid) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `PFVR_RESP_OKAY;
                case (s_axi_araddr)
                    `PFVR_OFF_STATUS: s_axi_rdata <= {24'h000000, command_complete_flag, 1'b0,
                        access_error_flag, protection_violation_flag, 2'h0,
                        any_read_error_flag, uncorrectable_error_flag};
                    `PFVR_OFF_INDEX: s_axi_rdata <= {29'h00000000, param_array_index};
                    `PFVR_OFF_PARAM: s_axi_rdata <= {16'h0000, bus_rdata};
                    `PFVR_OFF_MODE: s_axi_rdata <= {29'h00000000, cmd_allowed};
                    `PFVR_OFF_PROT: s_axi_rdata <= {16'h0000, prot_base};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `PFVR_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Software settings
    always @(posedge aclk) begin
        if (!aresetn) begin
            param_array_index <= 3'h0;
            cmd_allowed <= `PFVR_RST_MODE;
            prot_base <= `PFVR_RST_PROT;
        end else if (command_complete_flag) begin
            if (wr_index) param_array_index <= w_data[2:0];
            if (wr_mode) cmd_allowed <= w_data[2:0];
            if (wr_prot) prot_base <= w_data[15:0];
        end
    end

    // Status flags; a hardware set wins over a software clear
    reg set_acc;
    reg set_prot;
    reg set_any;
    reg set_unc;

    always @* begin
        set_acc = (state == S_CHECK) && acc_err;
        set_prot = (state == S_CHECK) && !acc_err && prot_err;
        set_any = 1'b0;
        set_unc = 1'b0;
        if (fl_ack && fl_req && !fl_we) begin
            if (state == S_RD && cmd_ev) begin
                set_any = rd_bad || (fl_rdata != `PFVR_ERASED);
                set_unc = fl_runc;
            end else if (state == S_RD && cmd_once) begin
                set_any = rd_bad;
                set_unc = fl_runc;
            end else if (state == S_RD) begin
                set_any = rd_bad || (fl_rdata != prog_data);
                set_unc = fl_runc;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            access_error_flag <= 1'b0;
            protection_violation_flag <= 1'b0;
            any_read_error_flag <= 1'b0;
            uncorrectable_error_flag <= 1'b0;
        end else begin
            access_error_flag <= set_acc || (access_error_flag && !clr_acc);
            protection_violation_flag <= set_prot || (protection_violation_flag && !clr_prot);
            if (launch) begin
                any_read_error_flag <= 1'b0;
                uncorrectable_error_flag <= 1'b0;
            end else begin
                any_read_error_flag <= any_read_error_flag || set_any;
                uncorrectable_error_flag <= uncorrectable_error_flag || set_unc;
            end
        end
    end

    // Command sequencer
    always @(posedge aclk) begin
        if (!aresetn) begin
            state <= S_IDLE;
            command_complete_flag <= 1'b1;
            launch_idx <= 3'h0;
            fetch_idx <= 3'h0;
            cur_addr <= 23'h000000;
            remaining <= 16'h0000;
            phrase <= 64'h0000000000000000;
            store_cnt <= 2'h0;
            fl_req <= 1'b0;
            fl_we <= 1'b0;
            fl_once <= 1'b0;
            fl_addr <= 23'h000000;
            fl_wdata <= 64'h0000000000000000;
            pflash_read_invalid <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (launch) begin
                        command_complete_flag <= 1'b0;
                        launch_idx <= param_array_index;
                        fetch_idx <= 3'h0;
                        state <= S_FETCH;
                    end
                end
                S_FETCH: state <= S_CAPT;
                S_CAPT: begin
                    prm[fetch_idx] <= seq_rdata;
                    if (fetch_idx == `PFVR_IX_LAST) begin
                        state <= S_CHECK;
                    end else begin
                        fetch_idx <= fetch_idx + 3'h1;
                        state <= S_FETCH;
                    end
                end
                S_CHECK: begin
                    cur_addr <= {prm[0][6:0], prm[1]};
                    remaining <= prm[2];
                    fl_addr <= {prm[0][6:0], prm[1]};
                    fl_wdata <= prog_data;
                    if (acc_err || prot_err) begin
                        state <= S_DONE;
                    end else if (cmd_once) begin
                        fl_once <= 1'b1;
                        fl_addr <= {7'h00, prm[1][12:0], 3'h0};
                        fl_req <= 1'b1;
                        pflash_read_invalid <= 1'b1;
                        state <= S_RD;
                    end else if (cmd_ev) begin
                        fl_req <= 1'b1;
                        state <= S_RD;
                    end else begin
                        fl_we <= 1'b1;
                        fl_req <= 1'b1;
                        state <= S_WR;
                    end
                end
                S_WR: begin
                    if (fl_ack) begin
                        fl_we <= 1'b0;
                        state <= S_RD;
                    end
                end
                S_RD: begin
                    if (fl_ack && fl_req) begin
                        fl_req <= 1'b0;
                        if (cmd_once) begin
                            phrase <= fl_rdata;
                            store_cnt <= 2'h0;
                            state <= S_STORE;
                        end else if (cmd_ev && remaining != 16'h0001) begin
                            remaining <= remaining - 16'h0001;
                            cur_addr <= cur_addr + 23'h000008;
                            fl_addr <= cur_addr + 23'h000008;
                            fl_req <= 1'b1;
                        end else begin
                            state <= S_DONE;
                        end
                    end else if (!fl_req) begin
                        fl_req <= 1'b1;
                    end
                end
                S_STORE: begin
                    store_cnt <= store_cnt + 2'h1;
                    if (store_cnt == 2'h3) state <= S_DONE;
                end
                S_DONE: begin
                    fl_once <= 1'b0;
                    pflash_read_invalid <= 1'b0;
                    command_complete_flag <= 1'b1;
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // pfvr_seq
`default_nettype wire

// ==== logic/pfvr_seq_top_note.v ====
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ==== verification/pfvr_seq_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module pfvr_seq_chk (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // Flash port
    input wire logic fl_req,
    input wire logic fl_we,
    input wire logic fl_once,
    input wire logic [22:0] fl_addr,
    input wire logic [63:0] fl_wdata,
    input wire logic fl_ack,
    input wire logic pflash_read_invalid
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_req_holds: assert property (
        fl_req && !fl_ack && !$past(fl_ack) |=> fl_req && $stable(fl_addr) && $stable(fl_wdata))
        else $error("flash request changed before ack");
    a_write_verify: assert property (
        fl_req && fl_we && fl_ack |-> ##[1:2] (fl_req && !fl_we && $stable(fl_addr)))
        else $error("program not followed by read-back");
    a_phrase_align: assert property (
        fl_req |-> fl_addr[2:0] == 3'h0)
        else $error("flash address not phrase aligned");
    a_valid_block: assert property (
        fl_req && !fl_once |-> fl_addr[22])
        else $error("flash access outside program flash");
    a_once_field: assert property (
        fl_req && fl_once |-> !fl_we && fl_addr[22:6] == 17'h0)
        else $error("one-time read outside its field");
    a_once_blocks_reads: assert property (
        fl_req && fl_once |-> pflash_read_invalid)
        else $error("ordinary reads not blocked during one-time read");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[2:3] s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read response late");

    c_program: cover property (fl_we && fl_ack);
    c_once: cover property (fl_once && fl_ack);
    c_verify: cover property (fl_ack && !fl_we && !fl_once);
endmodule // pfvr_seq_chk

bind pfvr_seq pfvr_seq_chk u_pfvr_seq_chk (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .fl_req(fl_req), .fl_we(fl_we), .fl_once(fl_once), .fl_addr(fl_addr),
    .fl_wdata(fl_wdata), .fl_ack(fl_ack), .pflash_read_invalid(pflash_read_invalid)
);
`default_nettype wire

// ==== verification/pfvr_seq_test.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "pfvr_consts.vh"
module pfvr_seq_test;
    logic aclk = 0, aresetn = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rv, rnd = 32'hD6A8BB53;
    logic [1:0] rsp, lat = 0;
    logic fl_ack = 0, fl_rerr = 0, fl_runc = 0, ferr = 0, ack_d = 0;
    logic [63:0] fl_rdata = 0, mem = 0, wd = 0;
    logic [22:0] wa = 0, ra = 0;
    logic [15:0] w [0:5] = '{default: 16'h0};
    int failures = 0, tests_run = 0, nwr = 0, nrd = 0, n0;
    wire awready, wready, bvalid, arready, rvalid, fl_req, fl_we, fl_once, rd_inv;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [22:0] fl_addr;
    wire [63:0] fl_wdata;

    always #2 aclk = ~aclk;

    pfvr_seq u_pfvr_seq (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .fl_req(fl_req), .fl_we(fl_we), .fl_once(fl_once), .fl_addr(fl_addr),
        .fl_wdata(fl_wdata), .fl_ack(fl_ack), .fl_rdata(fl_rdata), .fl_rerr(fl_rerr),
        .fl_runc(fl_runc), .pflash_read_invalid(rd_inv)
    );

    // Flash array stand-in: random latency, lines toggle outside answers
    always @(posedge aclk) begin
        fl_ack <= 0;
        ack_d <= fl_ack;
        fl_rdata <= ~fl_rdata;
        fl_rerr <= ~fl_rerr;
        fl_runc <= ~fl_runc;
        if (fl_req && !fl_ack && !ack_d) begin
            if (lat != 0) begin
                lat <= lat - 1;
            end else begin
                lat <= rnd[1:0];
                fl_ack <= 1;
                fl_rdata <= mem;
                fl_rerr <= ferr && !fl_we;
                fl_runc <= ferr && !fl_we;
                if (fl_we) begin
                    mem <= fl_wdata;
                    wd <= fl_wdata;
                    wa <= fl_addr;
                    nwr <= nwr + 1;
                end else begin
                    ra <= fl_addr;
                    nrd <= nrd + 1;
                end
            end
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic [63:0] st(input logic acc, input logic pv, input logic [1:0] mg);
        return {56'h0, 2'b10, acc, pv, 2'b00, mg};
    endfunction

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        if (wr) begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1;
            wvalid <= 1;
            bready <= 1;
        end else begin
            araddr <= a;
            arvalid <= 1;
            rready <= 1;
        end
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (arready) arvalid <= 0;
        end while (!(wr ? bvalid : rvalid));
        bready <= 0;
        rready <= 0;
        rv = rdata;
        rsp = wr ? bresp : rresp;
    endtask

    task automatic put(input logic [2:0] i, input logic [15:0] d);
        bus(1, `PFVR_OFF_INDEX, {29'h0, i});
        bus(1, `PFVR_OFF_PARAM, {16'h0, d});
    endtask

    task automatic cmd(input logic [2:0] last, input logic [63:0] e);
        int k;
        for (k = 0; k < 6; k++) put(k[2:0], w[k]);
        bus(1, `PFVR_OFF_INDEX, {29'h0, last});
        bus(1, `PFVR_OFF_STATUS, 32'h80);
        k = 0;
        do begin
            bus(0, `PFVR_OFF_STATUS, 0);
            k++;
        end while (!rv[7] && k < 100);
        chk("status", {56'h0, rv[7:0]}, e);
        bus(1, `PFVR_OFF_STATUS, 32'h30);
        chk("bresp", {62'h0, rsp}, {62'h0, `PFVR_RESP_OKAY});
    endtask

    task automatic end_of_test();
        if (failures == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #100000;
        failures++;
        end_of_test();
    end

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        bus(0, `PFVR_OFF_STATUS, 0);
        chk("status_rst", {56'h0, rv[7:0]}, st(0, 0, 0));
        bus(0, 8'h40, 0);
        chk("unmapped", {62'h0, rsp}, {62'h0, `PFVR_RESP_SLVERR});
        repeat (4) begin
            rnd = lfsr(rnd);
            w[0] = {`PFVR_CMD_PROG, 2'b01, rnd[5:0]};
            w[1] = {rnd[15:3], 3'h0};
            rnd = lfsr(rnd);
            {w[3], w[2]} = rnd;
            rnd = lfsr(rnd);
            {w[5], w[4]} = rnd;
            cmd(`PFVR_IX_PROG, st(0, 0, 0));
            chk("prog_addr", {41'h0, wa}, {41'h0, w[0][6:0], w[1]});
            chk("prog_data", wd, {w[5], w[4], w[3], w[2]});
        end
        n0 = nwr;
        cmd(3'h4, st(1, 0, 0));
        w[1][0] = 1;
        cmd(`PFVR_IX_PROG, st(1, 0, 0));
        w[1][0] = 0;
        w[0][6] = 0;
        cmd(`PFVR_IX_PROG, st(1, 0, 0));
        w[0][6] = 1;
        bus(1, `PFVR_OFF_MODE, 32'h3);
        cmd(`PFVR_IX_PROG, st(1, 0, 0));
        bus(1, `PFVR_OFF_MODE, 32'h7);
        bus(1, `PFVR_OFF_PROT, {16'h0, w[1]});
        cmd(`PFVR_IX_PROG, st(0, 1, 0));
        bus(1, `PFVR_OFF_PROT, 32'hFFFF);
        chk("no_write", nwr, n0);
        w[1] = w[1] ^ 16'h0008;
        ferr = 1;
        cmd(`PFVR_IX_PROG, st(0, 0, 3));
        ferr = 0;
        mem = '1;
        w[0] = {`PFVR_CMD_EV_SECT, 8'h41};
        w[1] = 16'hFFF0;
        w[2] = 16'h0002;
        n0 = nrd;
        cmd(`PFVR_IX_EV_SECT, st(0, 0, 0));
        chk("ev_reads", nrd - n0, 2);
        w[2] = 16'h0003;
        cmd(`PFVR_IX_EV_SECT, st(1, 0, 0));
        w[2] = 16'h0002;
        cmd(3'h1, st(1, 0, 0));
        mem[37] = 0;
        cmd(`PFVR_IX_EV_SECT, st(0, 0, 2));
        mem = '1;
        ferr = 1;
        cmd(`PFVR_IX_EV_SECT, st(0, 0, 3));
        ferr = 0;
        rnd = lfsr(rnd);
        mem = {rnd, ~rnd};
        w[0] = {`PFVR_CMD_RD_ONCE, 8'h00};
        w[1] = {13'h0, rnd[2:0]};
        cmd(`PFVR_IX_RD_ONCE, st(0, 0, 0));
        chk("once_addr", {41'h0, ra}, {58'h0, rnd[2:0], 3'h0});
        chk("once_end", {63'h0, rd_inv}, 64'h0);
        for (int k = 0; k < 4; k++) begin
            bus(1, `PFVR_OFF_INDEX, 32'(k + 2));
            bus(0, `PFVR_OFF_PARAM, 0);
            chk("once_word", {48'h0, rv[15:0]}, {48'h0, mem[16 * k +: 16]});
        end
        w[1] = 16'h0008;
        cmd(`PFVR_IX_RD_ONCE, st(1, 0, 0));
        w[1] = 16'h0007;
        cmd(3'h2, st(1, 0, 0));
        bus(1, `PFVR_OFF_MODE, 32'h5);
        cmd(`PFVR_IX_RD_ONCE, st(1, 0, 0));
        w[0] = 16'h0541;
        cmd(3'h2, st(1, 0, 0));
        end_of_test();
    end
endmodule // pfvr_seq_test
`default_nettype wire
